//--- dpr_pkg.sv
/*
  Shared constants and port bundles for the dual-port RAM port control block.
  Assumes both ports are clocked by one common clock and that all user-side
  inputs are synchronous to it except the output enables and the master reset.
*/
`default_nettype none

package dpr_pkg;

  // ----------------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 18;
  localparam int LANE_W = DATA_W / 2;
  localparam int NUM_PORTS = 2;
  localparam logic [ADDR_W-1:0] MASK_RST = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] ADDR_ZERO = {ADDR_W{1'b0}};
  // Mailbox that signals the right port, and the one that signals the left.
  localparam logic [ADDR_W-1:0] MBOX_RIGHT = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] MBOX_LEFT = {{(ADDR_W-1){1'b1}}, 1'b0};
  localparam logic RW_READ = 1'b1;
  localparam logic SEL_COUNTER = 1'b1;

  // ----------------------------------------------------------------------
  // Port bundles
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic chip_select_low_active;
    logic chip_select_high_active;
    logic read_write_sel;
    logic output_enable_n;
    logic address_strobe_n;
    logic counter_increment_enable_n;
    logic counter_clear_n;
    logic counter_or_mask_select;
    logic byte_lane_enable_0_n;
    logic byte_lane_enable_1_n;
    logic [ADDR_W-1:0] addr_in;
    logic [DATA_W-1:0] data_in;
  } dpr_in_s;

  typedef struct packed {
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic [ADDR_W-1:0] addr_out;
    logic addr_oe;
    logic counter_wrap_flag_n;
    logic mailbox_flag_n;
  } dpr_out_s;

endpackage

`default_nettype wire

//--- dpr_port_ctrl.sv
/*
  Port control and storage of a pipelined true dual-port RAM with burst
  counters, counter masks, wrap flags and mailbox flags.
  Assumes one common clock for both ports (clock-to-clock skew always met),
  synchronous inputs except output enable and master reset, and that the
  testbench resolves the data and address pins from the enables.
*/
// Summary of operation
// RULE1: Both chip selects active: write on select low, read on high; else float.
// RULE2: Output enable acts asynchronously; other inputs sampled on rising edge.
// RULE3: Chip select change takes effect one cycle later.
// RULE4: Strobe and increment enable low, counter select high: load address each edge.
// RULE5: Data pin state follows the controls sampled in the previous cycle.
// RULE6: Select first low with output enable low is a no-op turnaround cycle.
// RULE7: Host rewrites the location after a turnaround cycle.
// RULE8: Counter clear adds no dead cycle; access proceeds the same cycle.
// RULE9: Counter keeps incrementing after wrapping back, retransmitting the block.
// RULE10: Readback drives counter or mask onto address lines per select level.
// RULE11: Host releases the address bus before readback drives it.
// RULE12: Cross-port write is seen by the reader one cycle later.
// RULE13: Wrap flag always driven; low when unmasked counter reaches maximum.
// RULE14: Mailbox flag set on writer's edge, cleared on reader's edge.
// RULE15: All-ones address is the right port's mailbox.
// RULE16: Host keeps a byte lane active for mailbox accesses.
// RULE17: Master reset drives outputs inactive and clears the wrap flag.
// RULE18: Increment touches only unmasked counter bits, so that field wraps.
// RULE19: Counter clear zeroes unmasked counter bits, mask kept.
`timescale 1ns/1ps
`default_nettype none

module dpr_port_ctrl
  import dpr_pkg::*;
(
  input wire logic ref_clk, // System clock, both ports.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic master_reset_n, // Asynchronous master reset, active low.
  input wire dpr_in_s port_in [NUM_PORTS], // Port inputs, 0 left, 1 right.
  output dpr_out_s port_out [NUM_PORTS] // Port outputs, 0 left, 1 right.
);

  // ----------------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------------
  localparam int DEPTH = 2 ** ADDR_W;
  localparam logic [ADDR_W-1:0] MBOX_ADDR [NUM_PORTS] = '{MBOX_LEFT, MBOX_RIGHT};

  logic areset;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] acc_addr [NUM_PORTS];
  logic wr_en [NUM_PORTS];
  logic rd_en [NUM_PORTS];
  logic lane_any [NUM_PORTS];

  // Either reset source clears all control state.
  assign areset = rst | ~master_reset_n; // RULE17

  // Storage; ports are applied in order, so in a same-address collision the right port's write wins.
  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (wr_en[p]) begin // RULE1
        if (!port_in[p].byte_lane_enable_0_n) begin
          mem[acc_addr[p]][LANE_W-1:0] <= port_in[p].data_in[LANE_W-1:0];
        end
        if (!port_in[p].byte_lane_enable_1_n) begin
          mem[acc_addr[p]][DATA_W-1:LANE_W] <= port_in[p].data_in[DATA_W-1:LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-port logic
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam int OTHER = NUM_PORTS - 1 - p;

    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] next_cnt;
    logic [ADDR_W-1:0] next_mask;
    logic [ADDR_W-1:0] inc_val;
    logic cnt_change;
    logic wrap_hit;
    logic sel;
    logic nop;
    logic prev_rw;
    logic rd_pend;
    logic [ADDR_W-1:0] rd_addr;
    logic drive;
    logic [DATA_W-1:0] data_q;
    logic [ADDR_W-1:0] addr_q;
    logic addr_oe_q;
    logic wrap_n;
    logic mbox_n;
    logic mbox_set;
    logic mbox_clr;

    // Decode of the sampled controls.
    assign sel = ~port_in[p].chip_select_low_active & port_in[p].chip_select_high_active; // RULE1
    assign nop = ~port_in[p].read_write_sel & prev_rw & ~port_in[p].output_enable_n; // RULE6
    assign wr_en[p] = sel & ~port_in[p].read_write_sel & ~nop; // RULE1
    assign rd_en[p] = sel & port_in[p].read_write_sel;
    assign lane_any[p] = ~port_in[p].byte_lane_enable_0_n | ~port_in[p].byte_lane_enable_1_n; // RULE16
    assign acc_addr[p] = next_cnt; // RULE8
    assign inc_val = cnt + {{(ADDR_W-1){1'b0}}, 1'b1};

    // Counter and mask next values; mask bits set mark the counting field.
    always_comb begin
      next_cnt = cnt;
      next_mask = mask;
      cnt_change = 1'b0;
      wrap_hit = 1'b0;
      if (port_in[p].counter_or_mask_select == SEL_COUNTER) begin
        if (!port_in[p].counter_clear_n) begin
          next_cnt = cnt & ~mask; // RULE19
          cnt_change = 1'b1;
        end else if (!port_in[p].address_strobe_n && !port_in[p].counter_increment_enable_n) begin
          next_cnt = port_in[p].addr_in; // RULE4
          cnt_change = 1'b1;
        end else if (port_in[p].address_strobe_n && !port_in[p].counter_increment_enable_n) begin
          next_cnt = (cnt & ~mask) | (inc_val & mask); // RULE18 RULE9
          cnt_change = 1'b1;
          wrap_hit = ((inc_val & mask) == mask); // RULE13
        end
      end else begin
        if (!port_in[p].counter_clear_n) begin
          next_mask = MASK_RST;
        end else if (!port_in[p].address_strobe_n && !port_in[p].counter_increment_enable_n) begin
          next_mask = port_in[p].addr_in;
        end
      end
    end

    // Counter and mask registers.
    always_ff @(posedge ref_clk or posedge areset) begin
      if (areset) begin
        cnt <= ADDR_ZERO;
        mask <= MASK_RST;
      end else begin
        cnt <= next_cnt;
        mask <= next_mask;
      end
    end

    // Wrap flag, updated on every counter action and held otherwise.
    always_ff @(posedge ref_clk or posedge areset) begin
      if (areset) begin
        wrap_n <= 1'b1; // RULE17
      end else if (cnt_change) begin
        wrap_n <= ~wrap_hit; // RULE13
      end
    end

    // Read pipeline: controls sampled at one edge drive the pins after the next.
    always_ff @(posedge ref_clk or posedge areset) begin
      if (areset) begin
        prev_rw <= RW_READ;
        rd_pend <= 1'b0;
        rd_addr <= ADDR_ZERO;
        drive <= 1'b0;
        data_q <= '0;
      end else begin
        prev_rw <= port_in[p].read_write_sel;
        rd_pend <= rd_en[p]; // RULE3
        rd_addr <= acc_addr[p];
        drive <= rd_pend; // RULE5
        data_q <= mem[rd_addr]; // RULE12
      end
    end

    // Readback of counter or mask onto the address lines, one cycle per request.
    always_ff @(posedge ref_clk or posedge areset) begin
      if (areset) begin
        addr_q <= ADDR_ZERO;
        addr_oe_q <= 1'b0;
      end else begin
        addr_oe_q <= ~port_in[p].address_strobe_n & port_in[p].counter_increment_enable_n
                     & port_in[p].counter_clear_n;
        addr_q <= (port_in[p].counter_or_mask_select == SEL_COUNTER) ? cnt : mask; // RULE10
      end
    end

    // Mailbox flag of this port; a set in the clearing cycle wins.
    assign mbox_set = wr_en[OTHER] & lane_any[OTHER] & (acc_addr[OTHER] == MBOX_ADDR[p]); // RULE15
    assign mbox_clr = rd_en[p] & lane_any[p] & (acc_addr[p] == MBOX_ADDR[p]);
    always_ff @(posedge ref_clk or posedge areset) begin
      if (areset) begin
        mbox_n <= 1'b1;
      end else if (mbox_set) begin
        mbox_n <= 1'b0; // RULE14
      end else if (mbox_clr) begin
        mbox_n <= 1'b1; // RULE14
      end
    end

    // Outputs; the data enable is gated asynchronously by output enable.
    assign port_out[p].data_out = data_q;
    assign port_out[p].data_oe = drive & ~port_in[p].output_enable_n; // RULE2
    assign port_out[p].addr_out = addr_q;
    assign port_out[p].addr_oe = addr_oe_q;
    assign port_out[p].counter_wrap_flag_n = wrap_n;
    assign port_out[p].mailbox_flag_n = mbox_n;
  end

endmodule // dpr_port_ctrl

`default_nettype wire

//--- dpr_sva.sv
/* Checker for the port control block. Assumes one clock and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module dpr_sva
  import dpr_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic master_reset_n, // Master reset.
  input wire dpr_in_s port_in [NUM_PORTS], // Port inputs.
  input wire dpr_out_s port_out [NUM_PORTS] // Port outputs.
);
  // Port views and decoded requests.
  wire dpr_in_s a = port_in[0];
  wire dpr_in_s b = port_in[1];
  wire dpr_out_s y = port_out[0];
  wire dpr_out_s z = port_out[1];
  wire logic in_rst = rst || !master_reset_n;
  wire logic sel0 = !a.chip_select_low_active && a.chip_select_high_active;
  wire logic sel1 = !b.chip_select_low_active && b.chip_select_high_active;
  wire logic lane0 = !a.byte_lane_enable_0_n || !a.byte_lane_enable_1_n;
  wire logic lane1 = !b.byte_lane_enable_0_n || !b.byte_lane_enable_1_n;
  wire logic ld0 = !a.address_strobe_n && !a.counter_increment_enable_n && a.counter_clear_n && a.counter_or_mask_select;
  wire logic rb0 = !a.address_strobe_n && a.counter_increment_enable_n && a.counter_clear_n;
  wire logic mw0 = sel0 && ld0 && lane0 && !a.read_write_sel && a.output_enable_n && a.addr_in == MBOX_RIGHT;
  wire logic mr1 = sel1 && b.read_write_sel && lane1 && b.counter_clear_n && b.counter_or_mask_select
    && !b.address_strobe_n && !b.counter_increment_enable_n && b.addr_in == MBOX_RIGHT;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !master_reset_n);
  // The read pipeline is cleared by reset, so requests seen in a reset cycle are not expected.
  property p_drive;
    !$past(in_rst) && !$past(in_rst, 2) |-> y.data_oe == ($past(sel0 && a.read_write_sel, 2) && !a.output_enable_n);
  endproperty
  a_drive: assert property (p_drive) else $error("left read drive timing wrong");
  property p_oe;
    !$past(in_rst) && !$past(in_rst, 2) |-> z.data_oe == ($past(sel1 && b.read_write_sel, 2) && !b.output_enable_n);
  endproperty
  a_oe: assert property (p_oe) else $error("right read drive timing wrong");
  property p_rbk; !$past(in_rst) |-> y.addr_oe == $past(rb0); endproperty
  a_rbk: assert property (p_rbk) else $error("address readback enable wrong");
  property p_ldrb; ld0 ##1 rb0 |=> y.addr_out == $past(a.addr_in, 2); endproperty
  a_ldrb: assert property (p_ldrb) else $error("loaded address not read back");
  property p_wrap; $fell(y.counter_wrap_flag_n) |-> $past(a.address_strobe_n && !a.counter_increment_enable_n); endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag fell without increment");
  property p_rst; disable iff (1'b0) rst || !master_reset_n |-> !y.data_oe && !y.addr_oe && y.counter_wrap_flag_n; endproperty
  a_rst: assert property (p_rst) else $error("outputs active during reset");
  property p_mbset; mw0 |=> !z.mailbox_flag_n; endproperty
  a_mbset: assert property (p_mbset) else $error("right mailbox flag not set");
  property p_mbclr; mr1 && !mw0 |=> z.mailbox_flag_n; endproperty
  a_mbclr: assert property (p_mbclr) else $error("right mailbox flag not cleared");
  c_rd: cover property (sel0 && a.read_write_sel ##2 y.data_oe);
  c_rb: cover property (rb0 ##1 y.addr_oe);
  c_mb: cover property (mw0 ##1 !z.mailbox_flag_n);
endmodule // dpr_sva
bind dpr_port_ctrl dpr_sva u_sva (.ref_clk(ref_clk), .rst(rst), .master_reset_n(master_reset_n),
  .port_in(port_in), .port_out(port_out));
`default_nettype wire

//--- dpr_host.sv
/* Host model driving one port. Assumes set is called once a cycle at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module dpr_host
  import dpr_pkg::*;
(
  input wire dpr_out_s po, // Port outputs seen by the host.
  output var dpr_in_s pin // Port inputs driven by the host.
);
  // Packs select, read, oe_n, strobe_n, inc_n, clear_n, counter select; lanes stay on, address is inverted while readback drives.
  task automatic set(input logic [6:0] k, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    pin = {!k[6], k, 2'b00, po.addr_oe ? ~ad : ad, d};
  endtask
  // Idle controls from time zero.
  initial set(7'h2F, ADDR_ZERO, '0);
endmodule // dpr_host
`default_nettype wire

//--- dpr_port_ctrl_tb.sv
/* Testbench for the port control block. Assumes the package, the host model and the checker. */
`timescale 1ns/1ps
`default_nettype none
module dpr_port_ctrl_tb
  import dpr_pkg::*;
;
  localparam logic [6:0] IDLE = 7'h2F, WR = 7'h53, RD = 7'h63, TA = 7'h43, INC = 7'h6B;
  localparam logic [6:0] CLR = 7'h6D, RB = 7'h37, RBM = 7'h36, MSK = 7'h32, MCL = 7'h3C;
  logic ref_clk = 1'b0, rst = 1'b0, master_reset_n = 1'b1;
  int n_errors = 0, num_checks = 0, cyc = 0;
  dpr_in_s pin [NUM_PORTS];
  dpr_out_s po [NUM_PORTS];
  dpr_port_ctrl uut (.ref_clk(ref_clk), .rst(rst), .master_reset_n(master_reset_n), .port_in(pin), .port_out(po));
  dpr_host h0 (.po(po[0]), .pin(pin[0]));
  dpr_host h1 (.po(po[1]), .pin(pin[1]));
  // Clock, and a ceiling on run length.
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // One cycle of controls on both ports.
  task automatic cy(input logic [6:0] k0, input logic [ADDR_W-1:0] a0 = '0, input logic [DATA_W-1:0] d0 = '0,
                    input logic [6:0] k1 = IDLE, input logic [ADDR_W-1:0] a1 = '0);
    @(negedge ref_clk);
    h0.set(k0, a0, d0);
    h1.set(k1, a1, '0);
  endtask
  // Left read, compared when its word is driven.
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
    cy(RD, ad);
    cy(IDLE);
    @(negedge ref_clk);
    chk("left data", 32'(e), 32'(po[0].data_out));
    chk("left drive", 1, 32'(po[0].data_oe));
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    // Raised after every process waits, so the reset edge is never missed at time zero.
    rst <= 1'b1;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    cy(WR, 19'h6, 18'h2AAAA, RD, 19'h6);
    cy(IDLE);
    @(negedge ref_clk);
    chk("right data", 32'h2AAAA, 32'(po[1].data_out));
    chk("right drive", 1, 32'(po[1].data_oe));
    cy(WR, 19'h7, 18'h15555);
    cy(RD, 19'h7);
    cy(TA, 19'h7, 18'h0AAAA);
    rd(19'h7, 18'h15555);
    cy(WR, 19'h7, 18'h0AAAA);
    rd(19'h7, 18'h0AAAA);
    cy(MSK, 19'h3);
    for (int i = 0; i < 4; i++) cy(WR, ADDR_W'(8 + i), DATA_W'(256 + i));
    for (int i = 0; i < 7; i++) begin
      cy(i == 0 ? RD : i < 5 ? INC : IDLE, 19'h8);
      if (i > 1) chk("burst", 32'h100 + ((i - 2) % 4), 32'(po[0].data_out));
      if (i == 4) chk("wrap", 0, 32'(po[0].counter_wrap_flag_n));
    end
    cy(RD, 19'hA);
    cy(RB);
    cy(CLR);
    chk("counter", 32'hA, 32'(po[0].addr_out));
    chk("readback drive", 1, 32'(po[0].addr_oe));
    cy(RB);
    cy(IDLE);
    chk("cleared read", 32'h100, 32'(po[0].data_out));
    chk("cleared counter", 32'h8, 32'(po[0].addr_out));
    cy(RBM);
    cy(IDLE);
    chk("mask", 32'h3, 32'(po[0].addr_out));
    cy(MCL);
    cy(RBM);
    cy(IDLE);
    chk("mask cleared", 32'h7FFFF, 32'(po[0].addr_out));
    cy(MSK, 19'h3);
    cy(WR, MBOX_RIGHT, 18'h1);
    cy(IDLE);
    chk("mailbox set", 0, 32'(po[1].mailbox_flag_n));
    cy(IDLE, '0, '0, RD, MBOX_RIGHT);
    cy(IDLE);
    chk("mailbox clear", 1, 32'(po[1].mailbox_flag_n));
    cy(IDLE, '0, '0, WR, MBOX_LEFT);
    cy(IDLE);
    chk("left mailbox set", 0, 32'(po[0].mailbox_flag_n));
    cy(RD, MBOX_LEFT);
    cy(IDLE);
    chk("left mailbox clear", 1, 32'(po[0].mailbox_flag_n));
    cy(IDLE, '0, '0, RB);
    cy(IDLE, '0, '0, INC);
    chk("right counter", 32'h7FFFE, 32'(po[1].addr_out));
    chk("right readback drive", 1, 32'(po[1].addr_oe));
    cy(IDLE);
    chk("right wrap", 0, 32'(po[1].counter_wrap_flag_n));
    cy(RD, 19'hA);
    cy(INC);
    cy(IDLE);
    master_reset_n = 1'b0;
    @(negedge ref_clk);
    chk("reset wrap", 1, 32'(po[0].counter_wrap_flag_n));
    chk("reset right wrap", 1, 32'(po[1].counter_wrap_flag_n));
    chk("reset drive", 0, 32'(po[0].data_oe));
    master_reset_n = 1'b1;
    cy(IDLE);
    end_of_test();
  end
endmodule // dpr_port_ctrl_tb
`default_nettype wire
